/* File: rtl/tsfp_pkg.sv */
// constants for the transmission status frame packer
// assumes a 100 MHz system clock; used by the packer and its piecewise encoder
package tsfp_pkg;
  // clock and frame timing
  localparam int          CLK_MHZ          = 100;
  localparam int          FRAME_PERIOD_MS  = 20;
  localparam int          FRAME_CYCLES     = FRAME_PERIOD_MS * 1000 * CLK_MHZ;
  // identifier fields
  localparam logic [2:0]  ID_PRIORITY      = 3'h3;
  localparam logic [17:0] ID_PGN           = 18'h0FF30;
  localparam logic [7:0]  ID_SENDER        = 8'h03;
  localparam logic [28:0] FRAME_ID         = {ID_PRIORITY, ID_PGN, ID_SENDER};
  localparam logic [3:0]  FRAME_DLC        = 4'h8;
  // two-bit status codes in byte 3
  localparam logic [1:0]  ST_OFF           = 2'h0;
  localparam logic [1:0]  ST_ON            = 2'h1;
  localparam logic [1:0]  ST_UNSUPPORTED   = 2'h3;
  // byte 3 field positions (low bit of each pair)
  localparam int          POS_ACTIVE_ERR   = 0;
  localparam int          POS_INACTIVE_ERR = 2;
  localparam int          POS_WARNING      = 4;
  localparam int          POS_SHIFT        = 6;
  // special byte codes
  localparam logic [7:0]  CODE_FAULT       = 8'hFE;
  localparam logic [7:0]  CODE_UNSUPP      = 8'hFF;
  localparam logic [7:0]  CODE_MAX_VALID   = 8'hFD;
  localparam logic [7:0]  CODE_FILL        = 8'hFF;
  localparam logic [7:0]  CODE_PRESS_OFF   = 8'h00;
  localparam logic [7:0]  CODE_PRESS_ON    = 8'h96;
  // temperature offset in degrees
  localparam logic [9:0]  TEMP_OFFSET      = 10'h032;
  // piecewise scale: input in 0.1 units; breaks at 10.0 and 30.0
  localparam logic [15:0] SEG1_LIMIT       = 16'h0064;
  localparam logic [15:0] SEG2_LIMIT       = 16'h012C;
  localparam logic [7:0]  SEG_COUNTS       = 8'h64;
endpackage

/* File: rtl/tsfp_piecewise_enc.sv */
// piecewise encoder for speed and pressure bytes
// assumes the value arrives in tenths of a unit, sampled on sys_clk; one-cycle latency
module tsfp_piecewise_enc (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic [15:0] value_tenths,
  input  wire logic        fault,
  input  wire logic        unsupported,
  output logic      [7:0]  code_ff
);
  logic [15:0] seg3;
  logic [7:0]  nxt_code;

  // 0.1 per count to 10, 0.2 per count to 30, 1.0 per count after
  always_comb begin
    seg3     = (value_tenths - tsfp_pkg::SEG2_LIMIT) / 16'h000A;
    nxt_code = tsfp_pkg::CODE_MAX_VALID;
    if (unsupported) begin
      nxt_code = tsfp_pkg::CODE_UNSUPP;
    end else if (fault) begin
      nxt_code = tsfp_pkg::CODE_FAULT;
    end else if (value_tenths < tsfp_pkg::SEG1_LIMIT) begin
      nxt_code = value_tenths[7:0];
    end else if (value_tenths < tsfp_pkg::SEG2_LIMIT) begin
      nxt_code = 8'(tsfp_pkg::SEG_COUNTS + 8'((value_tenths - tsfp_pkg::SEG1_LIMIT) >> 1));
    end else if (seg3 < 16'h0036) begin
      // clamp keeps 254 and 255 unambiguous
      nxt_code = 8'(16'h00C8 + seg3);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      code_ff <= tsfp_pkg::CODE_UNSUPP;
    end else if (clk_en) begin
      code_ff <= nxt_code;
    end
  end
endmodule

/* File: rtl/tsfp_frame_packer.sv */
// transmission status frame packer: builds the periodic 8-byte status payload
// assumes status inputs come from logic on sys_clk; a can controller takes the frame
// Function
// - byte 3 bits 1-2: active errors, 00 none, 01 present, 11 unsupported
// - byte 3 bits 3-4: inactive errors, same code set
// - inactive indication counts only the volatile error store
// - byte 3 bits 5-6: warning off/on/unsupported, trigger is an input
// - byte 3 bits 7-8: shift in progress flag
// - byte 4 sump temperature plus 50
// - byte 5 converter-out temperature plus 50
// - temperature bytes: 254 sensor fault, 255 unsupported
// - temperature bytes come only from analogue sensors
// - byte 6 speed: 0.1, then 0.2, then 1 km/h per count
// - receiver sums each portion at its own factor
// - speed byte: 254 sensor fault, 255 unsupported
// - byte 7 pressure: 0.1, then 0.2, then 1 bar per count
// - pressure byte: 254 sensor fault, 255 unsupported
// - pressure switch: 0 when no pressure, 150 when pressure
// - extended id priority 3, pgn 65328, sender 3, dlc 8
// - send the frame every 20 ms
module tsfp_frame_packer #(
  parameter int FRAME_CYCLES = tsfp_pkg::FRAME_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // byte 3 sources
  input  wire logic        active_err,
  input  wire logic        active_err_supp,
  input  wire logic        inactive_err_volatile,
  input  wire logic        inactive_err_supp,
  input  wire logic        warning_on,
  input  wire logic        warning_supp,
  input  wire logic        shift_active,
  input  wire logic        shift_supp,
  // temperatures, signed whole degrees from analogue sensors
  input  wire logic [9:0]  sump_temp,
  input  wire logic        sump_fault,
  input  wire logic        sump_supp,
  input  wire logic [9:0]  conv_temp,
  input  wire logic        conv_fault,
  input  wire logic        conv_supp,
  // speed in 0.1 km/h, pressure in 0.1 bar
  input  wire logic [15:0] speed_tenths,
  input  wire logic        speed_fault,
  input  wire logic        speed_supp,
  input  wire logic [15:0] press_tenths,
  input  wire logic        press_fault,
  input  wire logic        press_supp,
  input  wire logic        press_is_switch,
  input  wire logic        press_switch_on,
  // frame handshake with the can controller
  input  wire logic        frame_ack,
  output logic             frame_valid_ff,
  output logic      [28:0] frame_id_ff,
  output logic      [3:0]  frame_dlc_ff,
  output logic      [63:0] frame_data_ff
);
  logic [31:0] period_cnt_ff;
  logic        tick_ff;
  logic        tick_d_ff;
  logic [7:0]  byte3_ff;
  logic [7:0]  byte4_ff;
  logic [7:0]  byte5_ff;
  logic [7:0]  speed_code;
  logic [7:0]  press_code;
  logic        sw_fault;
  logic [15:0] press_src;

  // two-bit field: reserved 10 can never be formed
  function automatic logic [1:0] status2(input logic flag, input logic supp);
    if (!supp) begin
      return tsfp_pkg::ST_UNSUPPORTED;
    end
    return flag ? tsfp_pkg::ST_ON : tsfp_pkg::ST_OFF;
  endfunction

  // temperature with +50 offset, clamped under the fault codes
  function automatic logic [7:0] temp_code(input logic [9:0] t, input logic flt,
                                           input logic supp);
    logic [10:0] sum;
    // sign-extended one bit so hot readings cannot wrap into the negative range
    sum = {t[9], t} + {1'b0, tsfp_pkg::TEMP_OFFSET};
    if (!supp) begin
      return tsfp_pkg::CODE_UNSUPP;
    end
    if (flt) begin
      return tsfp_pkg::CODE_FAULT;
    end
    if (sum[10]) begin
      return 8'h00;
    end
    if (sum > 11'(tsfp_pkg::CODE_MAX_VALID)) begin
      return tsfp_pkg::CODE_MAX_VALID;
    end
    return sum[7:0];
  endfunction

  // frame period counter; tick every 20 ms
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      period_cnt_ff <= 32'h0000_0000;
      tick_ff       <= 1'b0;
    end else if (clk_en) begin
      tick_ff <= 1'b0;
      if (period_cnt_ff == 32'(FRAME_CYCLES - 1)) begin
        period_cnt_ff <= 32'h0000_0000;
        tick_ff       <= 1'b1;
      end else begin
        period_cnt_ff <= period_cnt_ff + 32'h0000_0001;
      end
    end
  end

  // byte 3 to 5 snapshot taken on the tick, same cycle as the encoders
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      byte3_ff <= 8'hFF;
      byte4_ff <= tsfp_pkg::CODE_UNSUPP;
      byte5_ff <= tsfp_pkg::CODE_UNSUPP;
    end else if (clk_en && tick_ff) begin
      byte3_ff[tsfp_pkg::POS_ACTIVE_ERR +: 2]   <= status2(active_err, active_err_supp);
      // only the volatile store feeds this field
      byte3_ff[tsfp_pkg::POS_INACTIVE_ERR +: 2] <= status2(inactive_err_volatile,
                                                           inactive_err_supp);
      byte3_ff[tsfp_pkg::POS_WARNING +: 2]      <= status2(warning_on, warning_supp);
      byte3_ff[tsfp_pkg::POS_SHIFT +: 2]        <= status2(shift_active, shift_supp);
      // analogue readings only; switch inputs have no port here
      byte4_ff <= temp_code(sump_temp, sump_fault, sump_supp);
      byte5_ff <= temp_code(conv_temp, conv_fault, conv_supp);
    end
  end

  // speed byte, piecewise so a receiver sums each portion
  tsfp_piecewise_enc u_speed_enc (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .clk_en       (clk_en && tick_ff),
    .value_tenths (speed_tenths),
    .fault        (speed_fault),
    .unsupported  (!speed_supp),
    .code_ff      (speed_code)
  );

  // a switch bypasses the scaler: encode 30.0 would not give 150, so the mux sits after
  assign sw_fault  = press_is_switch ? 1'b0 : press_fault;
  assign press_src = press_tenths;

  tsfp_piecewise_enc u_press_enc (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .clk_en       (clk_en && tick_ff),
    .value_tenths (press_src),
    .fault        (sw_fault),
    .unsupported  (!press_supp),
    .code_ff      (press_code)
  );

  logic        sw_mode_ff;
  logic        sw_on_ff;

  // switch state captured with the rest of the snapshot
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sw_mode_ff <= 1'b0;
      sw_on_ff   <= 1'b0;
      tick_d_ff  <= 1'b0;
    end else if (clk_en) begin
      tick_d_ff <= tick_ff;
      if (tick_ff) begin
        sw_mode_ff <= press_is_switch && press_supp;
        sw_on_ff   <= press_switch_on;
      end
    end
  end

  // assemble and hold the frame until the controller takes it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      frame_valid_ff <= 1'b0;
      frame_id_ff    <= tsfp_pkg::FRAME_ID;
      frame_dlc_ff   <= tsfp_pkg::FRAME_DLC;
      frame_data_ff  <= {64{1'b1}};
    end else if (clk_en) begin
      if (tick_d_ff) begin
        // one load of all bytes keeps the payload consistent
        frame_valid_ff <= 1'b1;
        frame_id_ff    <= tsfp_pkg::FRAME_ID;
        frame_dlc_ff   <= tsfp_pkg::FRAME_DLC;
        frame_data_ff[7:0]   <= 8'hFF; // lever echo lives outside this block
        frame_data_ff[15:8]  <= 8'hFF; // gear echo lives outside this block
        frame_data_ff[23:16] <= byte3_ff;
        frame_data_ff[31:24] <= byte4_ff;
        frame_data_ff[39:32] <= byte5_ff;
        frame_data_ff[47:40] <= speed_code;
        frame_data_ff[55:48] <= sw_mode_ff ? (sw_on_ff ? tsfp_pkg::CODE_PRESS_ON
                                                       : tsfp_pkg::CODE_PRESS_OFF)
                                           : press_code;
        frame_data_ff[63:56] <= tsfp_pkg::CODE_FILL;
      end else if (frame_ack) begin
        frame_valid_ff <= 1'b0;
      end
    end
  end
endmodule

/* File: verification/tsfp_frame_packer_sva.sv */
// assertions on the status frame packer outputs
// assumes a bind to tsfp_frame_packer; one clock, sync reset
module tsfp_frame_packer_sva #(
  parameter int FRAME_CYCLES = 20
) (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic        frame_ack,
  input wire logic        frame_valid_ff,
  input wire logic [28:0] frame_id_ff,
  input wire logic [3:0]  frame_dlc_ff,
  input wire logic [63:0] frame_data_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  int   gap_ff;
  logic seen_ff;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // run cycles since the last new frame; unacked frames make no rise, hence the modulo
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gap_ff  <= 0;
      seen_ff <= 1'b0;
    end else if ($rose(frame_valid_ff)) begin
      // the edge where the rise is seen counts only if the counter ran on it
      gap_ff  <= clk_en ? 1 : 0;
      seen_ff <= 1'b1;
    end else if (clk_en) begin
      gap_ff  <= gap_ff + 1;
    end
  end
  a_ident_const: assert property (frame_id_ff == 29'h0CFF3003)
    else $error("frame identifier wrong");
  a_length_const: assert property (frame_dlc_ff == 4'h8)
    else $error("frame length wrong");
  a_fill_last: assert property (frame_data_ff[63:56] == 8'hFF)
    else $error("last byte not all ones");
  a_no_reserved: assert property (frame_data_ff[17:16] != 2'h2 && frame_data_ff[19:18] != 2'h2 &&
    frame_data_ff[21:20] != 2'h2 && frame_data_ff[23:22] != 2'h2) else $error("reserved code sent");
  a_valid_hold: assert property (frame_valid_ff && !frame_ack |=> frame_valid_ff)
    else $error("valid dropped without ack");
  a_fall_cause: assert property ($fell(frame_valid_ff) |-> $past(frame_ack) && $past(clk_en))
    else $error("valid fell without taken ack");
  a_data_on_frame: assert property ($changed(frame_data_ff) |-> frame_valid_ff)
    else $error("payload changed outside a frame");
  a_hold_frozen: assert property (!clk_en |=> $stable(frame_data_ff) && $stable(frame_valid_ff))
    else $error("frame moved while frozen");
  a_frame_period: assert property ($rose(frame_valid_ff) && seen_ff |-> gap_ff % FRAME_CYCLES == 0)
    else $error("frame spacing wrong");
endmodule
bind tsfp_frame_packer tsfp_frame_packer_sva #(.FRAME_CYCLES(FRAME_CYCLES)) i_tsfp_frame_packer_sva (
  .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .frame_ack(frame_ack),
  .frame_valid_ff(frame_valid_ff), .frame_id_ff(frame_id_ff), .frame_dlc_ff(frame_dlc_ff),
  .frame_data_ff(frame_data_ff));

/* File: verification/tsfp_can_model.sv */
// can controller stand-in: takes each offered frame with an ack pulse
// assumes frame valid from the packer on sys_clk
module tsfp_can_model (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic frame_valid_ff,
  input  wire logic slow,
  output logic      ack_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_ff;
  // slow wait still well inside one frame period, so no frame is lost
  always_ff @(posedge sys_clk) begin
    if (reset || !frame_valid_ff) begin
      cnt_ff <= 4'h0;
      ack_ff <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
      ack_ff <= (cnt_ff == (slow ? 4'h6 : 4'h1));
    end
  end
endmodule

/* File: verification/tsfp_frame_packer_test.sv */
// bench for the status frame packer with a short frame period
// assumes the checker bind and the can stand-in are compiled first
module tsfp_frame_packer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 0, reset = 1, clk_en = 1, slow = 0;
  logic        frame_ack, frame_valid_ff;
  logic [7:0]  f = 8'hAA, m = 8'h55;
  logic [1:0]  sw = 2'h0;
  logic [9:0]  st = 10'h0, ct = 10'h0;
  logic [15:0] sp = 16'h0, pr = 16'h0;
  logic [28:0] frame_id_ff;
  logic [3:0]  frame_dlc_ff;
  logic [63:0] frame_data_ff;
  int          num_errors = 0, compares = 0;
  always #5 sys_clk = ~sys_clk;
  // f: supp/flag pairs, shift high; m: fault/supp pairs, sump high
  tsfp_frame_packer #(.FRAME_CYCLES(20)) i_tsfp_frame_packer (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .active_err(f[0]),
    .active_err_supp(f[1]), .inactive_err_volatile(f[2]), .inactive_err_supp(f[3]),
    .warning_on(f[4]), .warning_supp(f[5]), .shift_active(f[6]), .shift_supp(f[7]),
    .sump_temp(st), .sump_fault(m[7]), .sump_supp(m[6]), .conv_temp(ct), .conv_fault(m[5]),
    .conv_supp(m[4]), .speed_tenths(sp), .speed_fault(m[3]), .speed_supp(m[2]),
    .press_tenths(pr), .press_fault(m[1]), .press_supp(m[0]), .press_is_switch(sw[1]),
    .press_switch_on(sw[0]), .frame_ack(frame_ack), .frame_valid_ff(frame_valid_ff),
    .frame_id_ff(frame_id_ff), .frame_dlc_ff(frame_dlc_ff), .frame_data_ff(frame_data_ff));
  tsfp_can_model i_tsfp_can_model (
    .sys_clk(sys_clk), .reset(reset), .frame_valid_ff(frame_valid_ff), .slow(slow),
    .ack_ff(frame_ack));
  task automatic check(input string nm, input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // bounded wait for a valid level, sampled off the active edge
  task automatic wait_lvl(input logic lvl);
    int n;
    n = 0;
    while (frame_valid_ff !== lvl && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 200) begin
      num_errors++;
      finish_test();
    end
  endtask
  // second frame is the first one surely sampled after the change
  task automatic run(input logic [7:0] fi, input logic [7:0] mi, input logic [1:0] swi,
                     input logic [9:0] s, input logic [9:0] c, input logic [15:0] v,
                     input logic [15:0] p, input logic [39:0] e);
    @(negedge sys_clk);
    f = fi;
    m = mi;
    sw = swi;
    st = s;
    ct = c;
    sp = v;
    pr = p;
    repeat (2) begin
      wait_lvl(1'b0);
      wait_lvl(1'b1);
    end
    check("payload", frame_data_ff, {8'hFF, e, 16'hFFFF});
  endtask
  // expected bytes listed as byte 7 down to byte 3
  initial begin
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 0;
    check("reset data", frame_data_ff, {64{1'b1}});
    check("reset valid", {63'h0, frame_valid_ff}, 64'h0);
    check("ident", {31'h0, frame_dlc_ff, frame_id_ff}, {31'h0, 4'h8, 29'h0CFF3003});
    run(8'hAA, 8'h55, 2'h0, 10'h000, 10'h3CE, 16'h0063, 16'h0064, 40'h64_63_00_32_00);
    run(8'hFF, 8'h55, 2'h0, 10'h0C8, 10'h0CB, 16'h019A, 16'h00C4, 40'h94_D3_FD_FA_55);
    run(8'h55, 8'hAA, 2'h3, 10'h010, 10'h010, 16'h0010, 16'h0010, 40'hFF_FF_FF_FF_FF);
    run(8'hAA, 8'hFF, 2'h0, 10'h010, 10'h010, 16'h0010, 16'h0010, 40'hFE_FE_FE_FE_00);
    // hot readings clamp under the fault codes; speed 30.0 sits on the third segment start
    run(8'hAA, 8'h55, 2'h0, 10'h1F4, 10'h0CC, 16'h012C, 16'h0063, 40'h63_C8_FD_FD_00);
    slow = 1;
    run(8'hEB, 8'h55, 2'h3, 10'h3C4, 10'h014, 16'h270F, 16'h0010, 40'h96_FD_46_00_41);
    run(8'hAA, 8'h55, 2'h2, 10'h000, 10'h000, 16'h012B, 16'h01F4, 40'h00_C7_32_32_00);
    clk_en = 0;
    f = 8'hFF;
    repeat (30) @(negedge sys_clk);
    check("frozen", frame_data_ff, {8'hFF, 40'h00_C7_32_32_00, 16'hFFFF});
    clk_en = 1;
    finish_test();
  end
endmodule
